// ### rtl/motion_status_defs.svh
// Offsets, field positions, reset values and timing figures of the motion status bank.
// Included by the design modules and by the bench; holds definitions only.
`ifndef MOTION_STATUS_DEFS_SVH
`define MOTION_STATUS_DEFS_SVH

`define SPECIAL_WORDS        2256
`define IDX_REAL_MAP_LOW     500
`define IDX_REAL_MAP_HIGH    501
`define IDX_AMP_LOW          502
`define IDX_AMP_HIGH         503
`define IDX_MODE_ERR_A       505
`define IDX_MODE_ERR_B       506
`define IDX_TEST_ERR_LOW     510
`define IDX_TEST_ERR_HIGH    511
`define IDX_PULSE_ERR_A      513
`define IDX_PULSE_ERR_B      514
`define IDX_PULSE_ERR_C      515
`define IDX_MAX_CYCLE        524
`define IDX_SET_ERR_ARRAY    550
`define IDX_SET_ERR_INFO     551
`define IDX_IRQ_STATUS       2256
`define IDX_IRQ_ENABLE       2257
`define IDX_IRQ_CLEAR        2258
`define IDX_FLAGS            2259
`define IRQ_BITS             5
`define IRQ_MODE_SWITCH      0
`define IRQ_TEST_ERR         1
`define IRQ_PULSE_ERR        2
`define IRQ_SET_ERR          3
`define IRQ_AMP_CHANGE       4
`define WORD_RESET           16'h0000
`define AMP_SCAN_NS          400
`define CLK_PERIOD_NS        40
`define AMP_SCAN_CYCLES      ((`AMP_SCAN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/motion_status_pkg.sv
// Types shared by the motion status bank modules.
// Assumes the defs header is on the include path.
package motion_status_pkg;
  typedef struct packed {
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] haddr;
  } ahb_addr_type;

  typedef struct packed {
    logic        to_virtual;
    logic        to_real;
    logic        test_request;
    logic        pulse_gen_enable;
    logic        setting_error;
    logic        cycle_done;
  } engine_event_type;

  typedef enum logic [1:0] {
    AMP_IDLE,
    AMP_SCAN,
    AMP_LIVE
  } amp_state_type;
endpackage

// ### rtl/amp_presence_tracker.sv
// Tracks which servo amplifiers are present, one bit per axis.
// Assumes mounted and link_ok levels are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "motion_status_defs.svh"
module amp_presence_tracker
  import motion_status_pkg::*;
#(
  parameter int AXES = 32
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic [AXES-1:0] used_axes,
  input  wire logic [AXES-1:0] mounted,
  input  wire logic [AXES-1:0] link_ok,
  output logic      [AXES-1:0] presence,
  output logic                 changed
);
  localparam int SCAN_CYCLES = `AMP_SCAN_CYCLES;
  amp_state_type state;
  logic [7:0]    scan_count;
  logic [AXES-1:0] next_presence;

  assign next_presence = used_axes & mounted & link_ok;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state      <= AMP_IDLE;
      scan_count <= 8'h00;
    end else begin
      case (state)
        AMP_IDLE: begin
          state      <= AMP_SCAN;
          scan_count <= 8'h00;
        end
        AMP_SCAN: begin
          scan_count <= scan_count + 8'h01;
          if (scan_count == 8'(SCAN_CYCLES - 1)) begin
            state <= AMP_LIVE;
          end
        end
        AMP_LIVE: state <= AMP_LIVE;
        default: state <= AMP_IDLE;
      endcase
    end
  end

  // The first check after reset takes the full map; afterwards a lost link clears
  // its bit at once, and a newly mounted axis is recorded too.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      presence <= '0;
      changed  <= 1'b0;
    end else if (state == AMP_SCAN && scan_count == 8'(SCAN_CYCLES - 1)) begin
      presence <= next_presence;
      changed  <= 1'b1;
    end else if (state == AMP_LIVE) begin
      presence <= next_presence;
      changed  <= (next_presence != presence);
    end else begin
      changed  <= 1'b0;
    end
  end

  lost_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == AMP_LIVE) |=> (presence & ~$past(link_ok)) == '0)
    else $error("presence bit kept after link loss");
endmodule
`default_nettype wire

// ### rtl/motion_status_bank.sv
// Motion status register bank: monitor words updated by the motion engine, read over AHB-Lite.
// Assumes one AHB-Lite master, single word transfers, events synchronous to clk_sys.
// Operation
// - Monitor space of 2256 word indices from zero, control words at 2256-2259; only some carry status.
// - On real-to-virtual switch, capture which axes are real-mode axes.
// - On virtual-to-real switch, keep the axis map unchanged.
// - Axis map: axes 1-16 in low word, 17-32 in high word.
// - Mode switch error words update only on a virtual transition attempt.
// - Test request error words update only on a test-mode request.
// - Pulse generator error words update only on enable rising edge.
// - Setting error words written only when a setting error is detected.
// - Largest observed cycle time updated once per operation cycle.
// - Amplifier presence checked after reset; bit cleared when communication stops.
// - Refused test request sets error flag and stores per-axis operating bits.
`timescale 1ns/1ps
`default_nettype none
`include "motion_status_defs.svh"
module motion_status_bank
  import motion_status_pkg::*;
#(
  parameter int AXES = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire engine_event_type engine_event,
  input  wire logic [AXES-1:0]  real_axes,
  input  wire logic [31:0]      mode_switch_error,
  input  wire logic             mode_switch_failed,
  input  wire logic [AXES-1:0]  axes_operating,
  input  wire logic [47:0]      pulse_gen_error,
  input  wire logic [31:0]      setting_error,
  input  wire logic [15:0]      cycle_time,
  input  wire logic [AXES-1:0]  used_axes,
  input  wire logic [AXES-1:0]  amp_mounted,
  input  wire logic [AXES-1:0]  amp_link_ok,
  output logic                  irq
);
  logic [31:0]           real_mode_axis_map;
  logic [31:0]           mode_switch_error_info;
  logic [31:0]           test_request_error;
  logic                  test_request_error_flag;
  logic [47:0]           pulse_gen_axis_error;
  logic [15:0]           setting_error_array;
  logic [15:0]           setting_error_info;
  logic [15:0]           max_cycle_time;
  logic [AXES-1:0]       amp_presence;
  logic                  amp_changed;
  logic                  pulse_enable_prev;
  logic                  pulse_rise;
  logic                  test_refused;
  logic [`IRQ_BITS-1:0]  irq_status;
  logic [`IRQ_BITS-1:0]  irq_enable;
  logic [`IRQ_BITS-1:0]  irq_events;
  ahb_addr_type          addr_q;
  logic                  phase_valid;
  logic [31:0]           next_rdata;
  logic                  read_take;
  logic                  reg_write;

  // Word index of a byte address; each 16-bit word sits in its own aligned 32-bit slot.
  function automatic logic [29:0] word_index(input logic [31:0] addr);
    word_index = addr[31:2];
  endfunction

  function automatic logic [31:0] low_word(input logic [15:0] value);
    low_word = {16'h0000, value};
  endfunction

  amp_presence_tracker #(
    .AXES (AXES)
  ) u_amp (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .used_axes (used_axes),
    .mounted   (amp_mounted),
    .link_ok   (amp_link_ok),
    .presence  (amp_presence),
    .changed   (amp_changed)
  );

  assign pulse_rise   = engine_event.pulse_gen_enable && !pulse_enable_prev;
  assign test_refused = engine_event.test_request && (axes_operating != '0);

  // Only whole-word writes reach the control registers; narrower ones are ignored.
  assign read_take = hready && hsel && htrans[1] && !hwrite;
  assign reg_write = phase_valid && addr_q.hwrite && addr_q.hsize == 3'h2;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      real_mode_axis_map <= {`WORD_RESET, `WORD_RESET};
    end else if (engine_event.to_virtual) begin
      real_mode_axis_map <= real_axes;
    end
    // A return to real mode deliberately leaves the map alone.
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_switch_error_info <= {`WORD_RESET, `WORD_RESET};
    end else if (engine_event.to_virtual) begin
      mode_switch_error_info <= mode_switch_failed ? mode_switch_error : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      test_request_error      <= {`WORD_RESET, `WORD_RESET};
      test_request_error_flag <= 1'b0;
    end else if (engine_event.test_request) begin
      test_request_error      <= test_refused ? axes_operating : 32'h0000_0000;
      test_request_error_flag <= test_refused;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pulse_enable_prev    <= 1'b0;
      pulse_gen_axis_error <= '0;
    end else begin
      pulse_enable_prev <= engine_event.pulse_gen_enable;
      if (pulse_rise) begin
        pulse_gen_axis_error <= pulse_gen_error;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      setting_error_array <= `WORD_RESET;
      setting_error_info  <= `WORD_RESET;
    end else if (engine_event.setting_error) begin
      setting_error_array <= setting_error[15:0];
      setting_error_info  <= setting_error[31:16];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      max_cycle_time <= `WORD_RESET;
    end else if (engine_event.cycle_done && cycle_time > max_cycle_time) begin
      max_cycle_time <= cycle_time;
    end
  end

  assign irq_events = {amp_changed,
                       engine_event.setting_error,
                       pulse_rise && (pulse_gen_error != '0),
                       test_refused,
                       engine_event.to_virtual && mode_switch_failed};

  // AHB-Lite address phase is captured when the bus is ready; the slave never stalls.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_valid <= 1'b0;
      addr_q      <= '0;
    end else if (hready) begin
      phase_valid <= hsel && htrans[1];
      addr_q      <= '{htrans: htrans, hwrite: hwrite, hsize: hsize, haddr: haddr};
    end
  end

  // Set beats clear so that an event in the clearing cycle is never lost.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      if (reg_write &&
          word_index(addr_q.haddr) == 30'(`IDX_IRQ_CLEAR)) begin
        irq_status <= (irq_status & ~hwdata[`IRQ_BITS-1:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      if (reg_write &&
          word_index(addr_q.haddr) == 30'(`IDX_IRQ_ENABLE)) begin
        irq_enable <= hwdata[`IRQ_BITS-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_enable);

  // Monitor words ignore writes, and reads only select data.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (word_index(haddr))
      30'(`IDX_REAL_MAP_LOW):  next_rdata = low_word(real_mode_axis_map[15:0]);
      30'(`IDX_REAL_MAP_HIGH): next_rdata = low_word(real_mode_axis_map[31:16]);
      30'(`IDX_AMP_LOW):       next_rdata = low_word(amp_presence[15:0]);
      30'(`IDX_AMP_HIGH):      next_rdata = low_word(amp_presence[31:16]);
      30'(`IDX_MODE_ERR_A):    next_rdata = low_word(mode_switch_error_info[15:0]);
      30'(`IDX_MODE_ERR_B):    next_rdata = low_word(mode_switch_error_info[31:16]);
      30'(`IDX_TEST_ERR_LOW):  next_rdata = low_word(test_request_error[15:0]);
      30'(`IDX_TEST_ERR_HIGH): next_rdata = low_word(test_request_error[31:16]);
      30'(`IDX_PULSE_ERR_A):   next_rdata = low_word(pulse_gen_axis_error[15:0]);
      30'(`IDX_PULSE_ERR_B):   next_rdata = low_word(pulse_gen_axis_error[31:16]);
      30'(`IDX_PULSE_ERR_C):   next_rdata = low_word(pulse_gen_axis_error[47:32]);
      30'(`IDX_MAX_CYCLE):     next_rdata = low_word(max_cycle_time);
      30'(`IDX_SET_ERR_ARRAY): next_rdata = low_word(setting_error_array);
      30'(`IDX_SET_ERR_INFO):  next_rdata = low_word(setting_error_info);
      30'(`IDX_IRQ_STATUS):    next_rdata = {27'h0, irq_status};
      30'(`IDX_IRQ_ENABLE):    next_rdata = {27'h0, irq_enable};
      30'(`IDX_FLAGS):         next_rdata = {31'h0, test_request_error_flag};
      default:                 next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the address phase so it stands through the data phase.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (read_take) begin
      hrdata <= next_rdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Each monitor word moves only on its own event; error words then take the sampled value or zero, the maximum only a larger cycle time.
  map_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    engine_event.to_virtual |=> real_mode_axis_map == $past(real_axes))
    else $error("axis map not captured on virtual switch");
  map_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !engine_event.to_virtual |=> $stable(real_mode_axis_map))
    else $error("axis map changed without virtual switch");
  mode_err_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !engine_event.to_virtual |=> $stable(mode_switch_error_info))
    else $error("mode error words changed outside transition");
  mode_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (engine_event.to_virtual && mode_switch_failed) |=>
      mode_switch_error_info == $past(mode_switch_error))
    else $error("mode error words not captured on failed switch");
  mode_fail_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (engine_event.to_virtual && mode_switch_failed) |=> irq_status[`IRQ_MODE_SWITCH])
    else $error("failed mode switch not flagged");
  test_err_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !engine_event.test_request |=> $stable(test_request_error))
    else $error("test error words changed without request");
  test_accept_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (engine_event.test_request && !test_refused) |=>
      (test_request_error == 32'h0000_0000 && !test_request_error_flag))
    else $error("accepted test request left error words set");
  test_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    test_refused |=>
      (test_request_error_flag && test_request_error == $past(axes_operating)))
    else $error("refused test request not recorded");
  refuse_status_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    test_refused |=> irq_status[`IRQ_TEST_ERR])
    else $error("refused test request not flagged");
  pulse_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pulse_rise |=> $stable(pulse_gen_axis_error))
    else $error("pulse error words changed without enable rise");
  pulse_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pulse_rise |=> pulse_gen_axis_error == $past(pulse_gen_error))
    else $error("pulse error words not captured on enable rise");
  set_err_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !engine_event.setting_error |=> $stable(setting_error_info))
    else $error("setting error words changed without error");
  set_array_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !engine_event.setting_error |=> $stable(setting_error_array))
    else $error("setting error array changed without error");
  set_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    engine_event.setting_error |=>
      {setting_error_info, setting_error_array} == $past(setting_error))
    else $error("setting error words not captured");
  max_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    engine_event.cycle_done |=> max_cycle_time >= $past(cycle_time))
    else $error("maximum cycle time below observed cycle");
  cycle_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !engine_event.cycle_done |=> $stable(max_cycle_time))
    else $error("maximum cycle time changed without a cycle");
  read_clean_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (phase_valid && !addr_q.hwrite && !engine_event.test_request) |=>
      $stable(test_request_error_flag))
    else $error("read disturbed a flag");

  // Read data must carry the word addressed in the previous address phase.
  read_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (read_take && word_index(haddr) == 30'(`IDX_REAL_MAP_LOW) && !engine_event.to_virtual)
      |=> hrdata == low_word(real_mode_axis_map[15:0]))
    else $error("low axis map word read wrong");
  read_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (read_take && word_index(haddr) == 30'(`IDX_REAL_MAP_HIGH) && !engine_event.to_virtual)
      |=> hrdata == low_word(real_mode_axis_map[31:16]))
    else $error("high axis map word read wrong");
  unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (read_take && word_index(haddr) > 30'(`IDX_SET_ERR_INFO) &&
     word_index(haddr) < 30'(`SPECIAL_WORDS)) |=> hrdata == 32'h0000_0000)
    else $error("unmapped word read nonzero");
  rdata_stand_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !read_take |=> $stable(hrdata))
    else $error("read data changed outside a read");

  virtual_cover_c: cover property (@(posedge clk_sys) engine_event.to_virtual);
  refused_cover_c: cover property (@(posedge clk_sys) test_refused);
  irq_cover_c: cover property (@(posedge clk_sys) irq);
  pulse_cover_c: cover property (@(posedge clk_sys) pulse_rise);
  set_err_cover_c: cover property (@(posedge clk_sys) engine_event.setting_error);
endmodule
`default_nettype wire

// ### tb/motion_status_register_bank_bench.sv
// Self-checking bench for the motion status bank: AHB-Lite reads and writes, engine events.
// Assumes the defs header is on the include path and the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none
`include "motion_status_defs.svh"
module motion_status_register_bank_bench
  import motion_status_pkg::*;
;
  localparam logic [5:0] EV_VIRT = 6'h20;
  localparam logic [5:0] EV_REAL = 6'h10;
  localparam logic [5:0] EV_TEST = 6'h08;
  localparam logic [5:0] EV_SET  = 6'h02;
  localparam logic [5:0] EV_CYC  = 6'h01;

  logic             clk_sys;
  logic             rst_n;
  logic             hsel;
  logic             hwrite;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr;
  logic [31:0]      hwdata;
  wire logic        hreadyout;
  wire logic        hresp;
  wire logic        irq;
  wire logic [31:0] hrdata;
  engine_event_type engine_event;
  logic [31:0]      real_axes;
  logic [31:0]      mode_switch_error;
  logic             mode_switch_failed;
  logic [31:0]      axes_operating;
  logic [47:0]      pulse_gen_error;
  logic [31:0]      setting_error;
  logic [15:0]      cycle_time;
  logic [31:0]      used_axes;
  logic [31:0]      amp_mounted;
  logic [31:0]      amp_link_ok;
  int               n_mismatch;
  int               total_checks;
  logic [15:0]      ct_in [3];
  logic [15:0]      ct_exp [3];

  motion_status_bank #(.AXES(32)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .engine_event(engine_event),
    .real_axes(real_axes), .mode_switch_error(mode_switch_error),
    .mode_switch_failed(mode_switch_failed), .axes_operating(axes_operating),
    .pulse_gen_error(pulse_gen_error), .setting_error(setting_error),
    .cycle_time(cycle_time), .used_axes(used_axes), .amp_mounted(amp_mounted),
    .amp_link_ok(amp_link_ok), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task close_out;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Every wait on the bus is bounded so a stuck slave ends the run instead of hanging it.
  task wait_ready;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 64) begin
        n_mismatch++;
        close_out();
      end
      @(posedge clk_sys);
    end
  endtask

  task ahb(input logic wr, input int idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= 32'(idx * 4);
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input int idx, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, idx, wd, d);
    check({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  task rd_chk(input int idx, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, idx, 32'h0000_0000, d);
    check(d, exp);
  endtask

  task irq_chk(input logic exp);
    @(posedge clk_sys);
    check({31'h0000_0000, irq}, {31'h0000_0000, exp});
  endtask

  // Events are one-cycle pulses; two idle edges let the captured words settle.
  task pulse(input logic [5:0] m);
    engine_event <= engine_event_type'(engine_event | m);
    @(posedge clk_sys);
    engine_event <= engine_event_type'(engine_event & ~m);
    repeat (2) @(posedge clk_sys);
  endtask

  initial begin
    rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2;
    haddr = 32'h0000_0000; hwdata = 32'h0000_0000; engine_event = '0;
    real_axes = 32'h0000_0000; mode_switch_error = 32'h0000_0000; mode_switch_failed = 1'b0;
    axes_operating = 32'h0000_0000; pulse_gen_error = 48'h0000_0000_0000;
    setting_error = 32'h0000_0000; cycle_time = 16'h0000; used_axes = 32'h0001_000F;
    amp_mounted = 32'h0001_0007; amp_link_ok = 32'hFFFF_FFFF;
    n_mismatch = 0; total_checks = 0;
    ct_in = '{16'h0064, 16'h0032, 16'h00C8};
    ct_exp = '{16'h0064, 16'h0064, 16'h00C8};
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rd_chk(`IDX_REAL_MAP_LOW, 32'h0000_0000);
    rd_chk(`IDX_AMP_LOW, 32'h0000_0007);
    rd_chk(`IDX_AMP_HIGH, 32'h0000_0001);
    wr(`IDX_IRQ_CLEAR, 32'h0000_001F);
    wr(`IDX_IRQ_ENABLE, 32'h0000_001F);
    rd_chk(`IDX_IRQ_STATUS, 32'h0000_0000);
    real_axes <= 32'h8001_0003;
    pulse(EV_VIRT);
    rd_chk(`IDX_REAL_MAP_LOW, 32'h0000_0003);
    rd_chk(`IDX_REAL_MAP_HIGH, 32'h0000_8001);
    real_axes <= 32'h0000_FFFF;
    pulse(EV_REAL);
    rd_chk(`IDX_REAL_MAP_LOW, 32'h0000_0003);
    rd_chk(`IDX_REAL_MAP_HIGH, 32'h0000_8001);
    mode_switch_error <= 32'h1234_5678;
    mode_switch_failed <= 1'b1;
    pulse(EV_REAL);
    rd_chk(`IDX_MODE_ERR_A, 32'h0000_0000);
    pulse(EV_VIRT);
    rd_chk(`IDX_MODE_ERR_A, 32'h0000_5678);
    rd_chk(`IDX_MODE_ERR_B, 32'h0000_1234);
    irq_chk(1'b1);
    wr(`IDX_IRQ_CLEAR, 32'h0000_0001);
    irq_chk(1'b0);
    axes_operating <= 32'h0002_0005;
    pulse(EV_TEST);
    axes_operating <= 32'h0000_0000;
    rd_chk(`IDX_TEST_ERR_LOW, 32'h0000_0005);
    rd_chk(`IDX_TEST_ERR_HIGH, 32'h0000_0002);
    rd_chk(`IDX_FLAGS, 32'h0000_0001);
    rd_chk(`IDX_FLAGS, 32'h0000_0001);
    rd_chk(`IDX_IRQ_STATUS, 32'h0000_0002);
    // Masking must hide a pending status bit without clearing it.
    wr(`IDX_IRQ_ENABLE, 32'h0000_0000);
    irq_chk(1'b0);
    wr(`IDX_IRQ_ENABLE, 32'h0000_001F);
    irq_chk(1'b1);
    pulse(EV_TEST);
    rd_chk(`IDX_TEST_ERR_LOW, 32'h0000_0000);
    rd_chk(`IDX_FLAGS, 32'h0000_0000);
    wr(`IDX_IRQ_CLEAR, 32'h0000_001F);
    pulse_gen_error <= 48'hCCCC_BBBB_AAAA;
    repeat (3) @(posedge clk_sys);
    rd_chk(`IDX_PULSE_ERR_A, 32'h0000_0000);
    engine_event.pulse_gen_enable <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pulse_gen_error <= 48'h1111_2222_3333;
    rd_chk(`IDX_PULSE_ERR_A, 32'h0000_AAAA);
    rd_chk(`IDX_PULSE_ERR_B, 32'h0000_BBBB);
    rd_chk(`IDX_PULSE_ERR_C, 32'h0000_CCCC);
    engine_event.pulse_gen_enable <= 1'b0;
    setting_error <= 32'h00F0_0A0A;
    repeat (3) @(posedge clk_sys);
    rd_chk(`IDX_SET_ERR_ARRAY, 32'h0000_0000);
    pulse(EV_SET);
    rd_chk(`IDX_SET_ERR_ARRAY, 32'h0000_0A0A);
    rd_chk(`IDX_SET_ERR_INFO, 32'h0000_00F0);
    for (int i = 0; i < 3; i++) begin
      cycle_time <= ct_in[i];
      pulse(EV_CYC);
      rd_chk(`IDX_MAX_CYCLE, {16'h0000, ct_exp[i]});
    end
    cycle_time <= 16'hFFFF;
    repeat (3) @(posedge clk_sys);
    rd_chk(`IDX_MAX_CYCLE, 32'h0000_00C8);
    wr(`IDX_REAL_MAP_LOW, 32'h0000_0000);
    rd_chk(`IDX_REAL_MAP_LOW, 32'h0000_FFFF);
    rd_chk(600, 32'h0000_0000);
    wr(`IDX_IRQ_CLEAR, 32'h0000_001F);
    amp_link_ok <= 32'hFFFF_FFFD;
    repeat (4) @(posedge clk_sys);
    rd_chk(`IDX_AMP_LOW, 32'h0000_0005);
    rd_chk(`IDX_IRQ_STATUS, 32'h0000_0010);
    close_out();
  end
endmodule
`default_nettype wire
